/* src/bridge_cfg_pkg.sv */
// constants for the bridge configuration register block
// assumes an internal register access port from the device's serial-control slave
package bridge_cfg_pkg;
    localparam logic [7:0] CFG_OFFSET = 8'h54;
    localparam logic [7:0] STATUS_OFFSET = 8'h50;
    localparam int EXT_OVR_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int EDID_DIS_BIT = 5;
    localparam int AUTOSTART_DIS_BIT = 4;
    localparam int PROT_DIS_BIT = 3;
    localparam int TDM_EN_BIT = 2;
    localparam int AUDIO_SRC_BIT = 1;
    localparam int AUX_EN_BIT = 0;
    localparam int STS_RX_IRQ_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    typedef enum logic [2:0] {
        SEQ_STRAP,
        SEQ_EDID,
        SEQ_INIT,
        SEQ_PROT,
        SEQ_RUN
    } seq_state_t;
endpackage : bridge_cfg_pkg

/* src/bridge_control_config.sv */
// bridge configuration register with strap load and a small bridge sequencer
// assumes register accesses arrive synchronous to sys_clk_i from the serial-control slave
`timescale 1ns/100ps
module bridge_control_config
    import bridge_cfg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // strap pins
    input wire logic strap_pin_one_i,
    input wire logic strap_pin_zero_i,
    // receiver interrupt
    input wire logic rx_irq_pending_i,
    output logic irq_out_n_o,
    // sequencer handshakes
    output logic edid_load_req_o,
    input wire logic edid_load_done_i,
    output logic rx_init_req_o,
    input wire logic rx_init_done_i,
    output logic prot_setup_req_o,
    input wire logic prot_setup_done_i,
    // audio controls and sequencer-off flag
    output logic tdm_audio_en_o,
    output logic audio_local_sel_o,
    output logic aux_audio_en_o,
    output logic sequencer_off_o
);
    logic [7:0] cfg_r;
    logic strap_done_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic cfg_wr;

    assign cfg_wr = reg_wr_i && (reg_addr_i == CFG_OFFSET);

    // strap capture happens on the first edge after release, never under reset
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_r <= reg_wdata_i;
        end else if (!strap_done_r) begin
            cfg_r[EXT_OVR_BIT] <= strap_pin_one_i;
            cfg_r[EDID_DIS_BIT] <= strap_pin_one_i;
            cfg_r[AUX_EN_BIT] <= strap_pin_zero_i;
        end
    end

    // register reads
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= UNMAPPED_READ;
        end else if (reg_rd_i) begin
            if (reg_addr_i == CFG_OFFSET) begin
                reg_rdata_o <= cfg_r;
            end else if (reg_addr_i == STATUS_OFFSET) begin
                reg_rdata_o <= 8'(rx_irq_pending_i) << STS_RX_IRQ_BIT;
            end else begin
                reg_rdata_o <= UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_out_n_o <= 1'b1;
        end else begin
            irq_out_n_o <= !(cfg_r[IRQ_EN_BIT] && rx_irq_pending_i);
        end
    end

    // audio controls follow the register one clock later
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdm_audio_en_o <= 1'b0;
            audio_local_sel_o <= 1'b0;
            aux_audio_en_o <= 1'b0;
        end else begin
            tdm_audio_en_o <= cfg_r[TDM_EN_BIT];
            audio_local_sel_o <= cfg_r[AUDIO_SRC_BIT];
            aux_audio_en_o <= cfg_r[AUX_EN_BIT];
        end
    end

    // sequencer walks each step once; disabled steps are skipped, not retried
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SEQ_STRAP: begin
                if (strap_done_r) begin
                    state_nxt = SEQ_EDID;
                end
            end
            SEQ_EDID: begin
                if (cfg_r[EDID_DIS_BIT] || edid_load_done_i) begin
                    state_nxt = SEQ_INIT;
                end
            end
            SEQ_INIT: begin
                if (cfg_r[AUTOSTART_DIS_BIT] || rx_init_done_i) begin
                    state_nxt = SEQ_PROT;
                end
            end
            SEQ_PROT: begin
                if (cfg_r[PROT_DIS_BIT] || prot_setup_done_i) begin
                    state_nxt = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                state_nxt = SEQ_RUN;
            end
        endcase
        if (cfg_r[EXT_OVR_BIT] && state_r != SEQ_STRAP) begin
            state_nxt = state_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= SEQ_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edid_load_req_o <= 1'b0;
            rx_init_req_o <= 1'b0;
            prot_setup_req_o <= 1'b0;
            sequencer_off_o <= 1'b0;
        end else begin
            sequencer_off_o <= cfg_r[EXT_OVR_BIT];
            edid_load_req_o <= state_nxt == SEQ_EDID && !cfg_r[EDID_DIS_BIT]
                && !cfg_r[EXT_OVR_BIT] && !edid_load_done_i;
            rx_init_req_o <= state_nxt == SEQ_INIT && !cfg_r[AUTOSTART_DIS_BIT]
                && !cfg_r[EXT_OVR_BIT] && !rx_init_done_i;
            prot_setup_req_o <= state_nxt == SEQ_PROT && !cfg_r[PROT_DIS_BIT]
                && !cfg_r[EXT_OVR_BIT] && !prot_setup_done_i;
        end
    end

    ovr_no_req_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $past(cfg_r[EXT_OVR_BIT]) |-> !edid_load_req_o && !rx_init_req_o && !prot_setup_req_o)
        else $error("request issued under external override");
    strap_one_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        nrst_i && !strap_done_r && !cfg_wr |=> cfg_r[EXT_OVR_BIT] == $past(strap_pin_one_i)
        && cfg_r[EDID_DIS_BIT] == $past(strap_pin_one_i))
        else $error("strap one not loaded");
    irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ##1 irq_out_n_o == !($past(cfg_r[IRQ_EN_BIT]) && $past(rx_irq_pending_i)))
        else $error("interrupt pin gating wrong");
    edid_skip_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $past(cfg_r[EDID_DIS_BIT]) |-> !edid_load_req_o)
        else $error("remote load requested while disabled");
    init_skip_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $past(cfg_r[AUTOSTART_DIS_BIT]) |-> !rx_init_req_o)
        else $error("receiver init requested while disabled");
    prot_skip_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $past(cfg_r[PROT_DIS_BIT]) |-> !prot_setup_req_o)
        else $error("protection setup requested while disabled");
    audio_map_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ##1 audio_local_sel_o == $past(cfg_r[AUDIO_SRC_BIT])
        && tdm_audio_en_o == $past(cfg_r[TDM_EN_BIT]))
        else $error("audio controls do not follow register");
    strap_zero_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        nrst_i && !strap_done_r && !cfg_wr |=> cfg_r[AUX_EN_BIT] == $past(strap_pin_zero_i)
        ##1 aux_audio_en_o == $past(strap_pin_zero_i, 2))
        else $error("strap zero not loaded");
    status_rd_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == STATUS_OFFSET |=> reg_rdata_o[STS_RX_IRQ_BIT] == $past(rx_irq_pending_i))
        else $error("status bit 6 wrong");
    write_wins_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        nrst_i && cfg_wr |=> cfg_r == $past(reg_wdata_i))
        else $error("register write lost");
endmodule : bridge_control_config

/* bench/seq_responder.sv */
// far-side model answering one sequencer step handshake
// assumes the request stays high until done has been seen
`timescale 1ns/100ps
module seq_responder #(
    parameter int DELAY = 3
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    output logic done_o
);
    int cnt;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            cnt <= req_i ? cnt + 1 : 0;
            done_o <= req_i && (cnt >= DELAY);
        end
    end
endmodule : seq_responder

/* bench/tb.sv */
// self-checking bench for the bridge configuration register
// assumes three responders stand in for the receiver-side steps
`timescale 1ns/100ps
module tb;
    import bridge_cfg_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, s1 = 1, s0 = 1, irq = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic irq_n, er, ed, ir, id, pr, pd, tdm, loc, aux, off;
    logic [2:0] prev;
    int num_errors = 0, cmp_count = 0, cyc = 0, n_e, n_i, n_p;
    always #5 clk = ~clk;
    bridge_control_config dut_u (.sys_clk_i(clk), .nrst_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .strap_pin_one_i(s1),
        .strap_pin_zero_i(s0), .rx_irq_pending_i(irq), .irq_out_n_o(irq_n), .edid_load_req_o(er),
        .edid_load_done_i(ed), .rx_init_req_o(ir), .rx_init_done_i(id), .prot_setup_req_o(pr),
        .prot_setup_done_i(pd), .tdm_audio_en_o(tdm), .audio_local_sel_o(loc),
        .aux_audio_en_o(aux), .sequencer_off_o(off));
    // slow, prompt and medium answers
    seq_responder #(.DELAY(6)) edid_u (.sys_clk_i(clk), .nrst_i(rst_n), .req_i(er), .done_o(ed));
    seq_responder #(.DELAY(0)) init_u (.sys_clk_i(clk), .nrst_i(rst_n), .req_i(ir), .done_o(id));
    seq_responder #(.DELAY(3)) prot_u (.sys_clk_i(clk), .nrst_i(rst_n), .req_i(pr), .done_o(pd));
    // count request rises per step
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {n_e, n_i, n_p} = 0;
            prev = 3'b000;
        end else begin
            n_e += int'(er && !prev[2]);
            n_i += int'(ir && !prev[1]);
            n_p += int'(pr && !prev[0]);
            prev = {er, ir, pr};
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdat, exp);
    endtask : rd_reg
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic test_straps();
        rd_reg(CFG_OFFSET, 8'ha1);
        settle(30);
        chk({7'h00, off}, 8'h01);
        chk(8'(n_e + n_i + n_p), 8'h00);
    endtask : test_straps
    task automatic test_skip();
        wr_reg(CFG_OFFSET, 8'h20);
        settle(60);
        rd_reg(CFG_OFFSET, 8'h20);
        chk({7'h00, off}, 8'h00);
        chk(8'(n_e), 8'h00);
        chk(8'(n_i), 8'h01);
        chk(8'(n_p), 8'h01);
    endtask : test_skip
    task automatic test_audio();
        for (int i = 0; i < 3; i++) begin
            wr_reg(CFG_OFFSET, 8'h01 << i);
            settle(2);
            chk({5'h00, tdm, loc, aux}, 8'h01 << i);
        end
    endtask : test_audio
    task automatic test_irq();
        @(posedge clk) irq <= 1'b1;
        wr_reg(CFG_OFFSET, 8'h00);
        settle(2);
        chk({7'h00, irq_n}, 8'h01);
        wr_reg(CFG_OFFSET, 8'h40);
        settle(2);
        chk({7'h00, irq_n}, 8'h00);
        rd_reg(STATUS_OFFSET, 8'h40);
        rd_reg(8'h33, UNMAPPED_READ);
        @(posedge clk) irq <= 1'b0;
        settle(2);
        chk({7'h00, irq_n}, 8'h01);
    endtask : test_irq
    task automatic test_full_run();
        {rst_n, s1, s0} <= 3'b000;
        settle(3);
        @(posedge clk) rst_n <= 1'b1;
        settle(80);
        rd_reg(CFG_OFFSET, 8'h00);
        chk(8'(n_e + n_i + n_p), 8'h03);
    endtask : test_full_run
    // write lands on the strap edge, so it must beat both straps
    task automatic test_disable();
        {rst_n, s1, s0} <= 3'b011;
        settle(3);
        @(posedge clk) {rst_n, addr, wd, wr} <= {1'b1, CFG_OFFSET, 8'h18, 1'b1};
        @(posedge clk) wr <= 1'b0;
        settle(60);
        rd_reg(CFG_OFFSET, 8'h18);
        chk({7'h00, off}, 8'h00);
        chk(8'(n_e), 8'h01);
        chk(8'(n_i), 8'h00);
        chk(8'(n_p), 8'h00);
    endtask : test_disable
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle(3);
        test_straps();
        test_skip();
        test_audio();
        test_irq();
        test_full_run();
        test_disable();
        stop_test();
    end
endmodule : tb
